/* dbgbrk_pkg.sv */
// Constants shared by the debug breakpoint unit
package dbgbrk_pkg;
    // Geometry of the comparator bank
    localparam int NUM_CMP = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int REG_ADDR_W = 8;

    // Write-only register offsets on the serial debug port
    localparam logic [7:0] OFF_BP0_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFF_BP0_ADDR_HIGH = 8'h01;
    localparam logic [7:0] OFF_BP0_ADDR_UPPER = 8'h02;
    localparam logic [7:0] OFF_BP1_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFF_BP1_ADDR_HIGH = 8'h05;
    localparam logic [7:0] OFF_BP1_ADDR_UPPER = 8'h06;
    localparam logic [7:0] OFF_BP2_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFF_BP2_ADDR_HIGH = 8'h09;
    localparam logic [7:0] OFF_BP2_ADDR_UPPER = 8'h0a;
    localparam logic [7:0] OFF_BP3_ADDR_LOW = 8'h0c;
    localparam logic [7:0] OFF_BP3_ADDR_HIGH = 8'h0d;
    localparam logic [7:0] OFF_BP3_ADDR_UPPER = 8'h0e;
    localparam logic [7:0] OFF_BREAK_CONTROL = 8'h10;

    // Comparator window: offsets 0x00..0x0f, stride of four
    localparam logic [3:0] CMP_WINDOW_TOP = 4'h0;
    localparam logic [1:0] LANE_LOW = 2'h0;
    localparam logic [1:0] LANE_HIGH = 2'h1;
    localparam logic [1:0] LANE_UPPER = 2'h2;

    // Break control field positions
    localparam int BIT_BREAK_NEXT = 7;
    localparam int BIT_MATCH0_ENABLE = 3;
    localparam int BIT_IGNORE_LOW1 = 2;
    localparam int BIT_IGNORE_LOW0 = 1;
    localparam int BIT_SINGLE_STEP = 0;
    localparam logic [7:0] BREAK_CONTROL_RESET = 8'h00;

    // Cycles after reset release before the strap pins are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : dbgbrk_pkg

/* dbgbrk_unit.sv */
// Breakpoint unit of the serial debug port: comparators, break control
//
// Operation
// [RULE_01] Enabled comparator checks CPU address against its three bytes.
// [RULE_02] Long address mode compares the full 24-bit address bus.
// [RULE_03] 16-bit mode compares memory base byte above address bits 15..0.
// [RULE_04] A match halts the CPU in debug mode awaiting host commands.
// [RULE_05] Breaks land on instruction boundaries; non-first-byte matches wait.
// [RULE_06] Four comparators at offsets 4x, bytes low, high, upper.
// [RULE_07] Host writing break-next zero releases the halted CPU.
// [RULE_08] Writing break-next one forces a break on the next instruction.
// [RULE_09] Clock pin high, data pin low at reset end: break first.
// [RULE_10] A comparator break sets break-next automatically.
// [RULE_11] Control bits 6..3 enable comparators 3..0.
// [RULE_12] Bit 2 clear: comparator 1 must match all 24 bits.
// [RULE_13] Bit 2 set: comparator 1 matches bits 23..8, a page.
// [RULE_14] Host may arm several comparators together, e.g. branch targets.
// [RULE_15] Bit 1 gives comparator 0 the same low-byte ignore.
// [RULE_16] Bit 0 set: halt after every executed instruction.
// [RULE_17] Several simultaneous matches make one break event.
// [RULE_18] Break control resets to zero; comparator bytes undefined.
`timescale 1ns/10ps
`default_nettype none
module dbgbrk_unit #(
    parameter int NUM_CMP = dbgbrk_pkg::NUM_CMP
) (
    input wire logic CLK,                 // System clock
    input wire logic RST_B,               // Async reset, active low
    input wire logic DEBUG_CLOCK_PIN,     // Link clock, also strap level
    input wire logic DEBUG_DATA_PIN,      // Debug data pin level for strap
    input wire logic LINK_WR,             // Register write request, link side
    input wire logic [7:0] LINK_ADDR,     // Register offset
    input wire logic [7:0] LINK_WDATA,    // Register write data
    output logic LINK_READY,              // Link side may issue a write
    input wire logic CPU_ADDR_VALID,      // CPU address valid this cycle
    input wire logic CPU_FIRST_OPCODE,    // Address is first opcode fetch
    input wire logic CPU_INSTR_END,       // Instruction completes this cycle
    input wire logic [23:0] CPU_ADDR,     // CPU address bus
    input wire logic [7:0] CPU_MEMORY_BASE_BYTE, // Memory base byte
    input wire logic CPU_LONG_ADDRESS_MODE, // 24-bit mode when high
    output logic CPU_HALT,                // Hold CPU in debug mode
    output logic BREAK_PENDING            // Deferred break awaits boundary
);
    // Elaboration check: the bank decode serves exactly four comparators
    if (NUM_CMP != 4) begin : g_bad_num
        $error("NUM_CMP must be 4");
    end

    // Link domain state
    typedef struct packed {
        logic req_tgl;
        logic [7:0] addr;
        logic [7:0] data;
        logic ack_s1;
        logic ack_s2;
    } dbgbrk_link_s;

    // System domain state
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic clk_s1;
        logic clk_s2;
        logic dat_s1;
        logic dat_s2;
        logic strap_pend;
        logic [1:0] strap_cnt;
        logic [7:0] brk_ctl;
        logic [3:0][23:0] bp;
        logic pend;
        logic halt;
    } dbgbrk_sys_s;

    dbgbrk_link_s l_r;
    dbgbrk_link_s l_nxt;
    dbgbrk_sys_s s_r;
    dbgbrk_sys_s s_nxt;
    logic link_busy;
    logic wr_fire;
    logic [23:0] cmp_addr;
    logic any_hit;
    logic hw_set;
    logic sw_wr_ctl;

    // Compare one comparator, optionally ignoring the low byte
    function automatic logic addr_match(input logic [23:0] a,
                                        input logic [23:0] bp,
                                        input logic ign_low);
        logic eq_hi;
        logic eq_lo;
        eq_hi = (a[23:8] == bp[23:8]);
        eq_lo = (a[7:0] == bp[7:0]);    // see [RULE_12]
        return eq_hi && (ign_low || eq_lo);
    endfunction : addr_match

    // Replace one byte lane of a comparator address
    function automatic logic [23:0] lane_put(input logic [23:0] w,
                                             input logic [1:0] lane,
                                             input logic [7:0] d);
        logic [23:0] r;
        r = w;
        unique case (lane)
            dbgbrk_pkg::LANE_LOW: r[7:0] = d;
            dbgbrk_pkg::LANE_HIGH: r[15:8] = d;
            dbgbrk_pkg::LANE_UPPER: r[23:16] = d;
            default: r = w;
        endcase
        return r;
    endfunction : lane_put

    // Link side: hold the word and flip the request toggle once accepted
    assign link_busy = l_r.req_tgl != l_r.ack_s2;
    assign LINK_READY = !link_busy;

    always_comb
    begin
        l_nxt = l_r;
        l_nxt.ack_s1 = s_r.req_s3;
        l_nxt.ack_s2 = l_r.ack_s1;
        if (LINK_WR && !link_busy)
        begin
            l_nxt.addr = LINK_ADDR;
            l_nxt.data = LINK_WDATA;
            l_nxt.req_tgl = !l_r.req_tgl;
        end
    end

    // Link domain register
    always_ff @(posedge DEBUG_CLOCK_PIN or negedge RST_B)
    begin
        if (!RST_B)
            l_r <= '0;
        else
            l_r <= l_nxt;
    end

    // Address presented to the comparators depends on CPU mode
    always_comb
    begin
        if (CPU_LONG_ADDRESS_MODE)
            cmp_addr = CPU_ADDR;                        // see [RULE_02]
        else
            cmp_addr = {CPU_MEMORY_BASE_BYTE, CPU_ADDR[15:0]}; // see [RULE_03]
    end

    // OR of all enabled comparators, one event however many hit
    always_comb
    begin
        logic ign;
        ign = 1'b0;
        any_hit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ign = 1'b0;
            if (i == 1)
                ign = s_r.brk_ctl[dbgbrk_pkg::BIT_IGNORE_LOW1]; // see [RULE_13]
            if (i == 0)
                ign = s_r.brk_ctl[dbgbrk_pkg::BIT_IGNORE_LOW0]; // see [RULE_15]
            if (s_r.brk_ctl[dbgbrk_pkg::BIT_MATCH0_ENABLE + i]  // see [RULE_11]
                && addr_match(cmp_addr, s_r.bp[i], ign))        // see [RULE_01]
                any_hit = 1'b1;                                 // see [RULE_17]
        end
    end

    // Toggle edge marks a fresh host write; link word is stable by then
    assign wr_fire = s_r.req_s2 ^ s_r.req_s3;
    assign sw_wr_ctl = wr_fire && (l_r.addr == dbgbrk_pkg::OFF_BREAK_CONTROL);

    // System side: register writes, break detection, strap capture
    always_comb
    begin
        s_nxt = s_r;
        hw_set = 1'b0;
        s_nxt.req_s1 = l_r.req_tgl;
        s_nxt.req_s2 = s_r.req_s1;
        s_nxt.req_s3 = s_r.req_s2;
        s_nxt.clk_s1 = DEBUG_CLOCK_PIN;
        s_nxt.clk_s2 = s_r.clk_s1;
        s_nxt.dat_s1 = DEBUG_DATA_PIN;
        s_nxt.dat_s2 = s_r.dat_s1;
        // Host register writes
        if (wr_fire)
        begin
            if (l_r.addr[7:4] == dbgbrk_pkg::CMP_WINDOW_TOP)    // see [RULE_06]
                s_nxt.bp[l_r.addr[3:2]] =
                    lane_put(s_r.bp[l_r.addr[3:2]], l_r.addr[1:0], l_r.data);
            if (sw_wr_ctl)
                s_nxt.brk_ctl = l_r.data;                       // see [RULE_07]
        end
        // Break sources while the CPU is running
        if (!s_r.halt && !s_r.strap_pend)
        begin
            if (CPU_ADDR_VALID && any_hit)
            begin
                if (CPU_FIRST_OPCODE)
                    hw_set = 1'b1;                              // see [RULE_04]
                else
                    s_nxt.pend = 1'b1;                          // see [RULE_05]
            end
            if (CPU_INSTR_END)
            begin
                // A late match in the ending instruction itself breaks too
                if (s_nxt.pend)
                    hw_set = 1'b1;                              // see [RULE_05]
                if (s_r.brk_ctl[dbgbrk_pkg::BIT_SINGLE_STEP])
                    hw_set = 1'b1;                              // see [RULE_16]
                s_nxt.pend = 1'b0;
            end
        end
        // Strap sampled once synchronisers have settled after reset
        if (s_r.strap_pend)
        begin
            if (s_r.strap_cnt == dbgbrk_pkg::STRAP_SETTLE)
            begin
                s_nxt.strap_pend = 1'b0;
                if (s_r.clk_s2 && !s_r.dat_s2)
                    hw_set = 1'b1;                              // see [RULE_09]
            end
            else
                s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
        end
        // Hardware set wins over a simultaneous clearing write
        if (hw_set)
        begin
            s_nxt.brk_ctl[dbgbrk_pkg::BIT_BREAK_NEXT] = 1'b1;   // see [RULE_10]
            s_nxt.pend = 1'b0;
        end
        s_nxt.halt = s_nxt.brk_ctl[dbgbrk_pkg::BIT_BREAK_NEXT] // see [RULE_08]
            || s_nxt.strap_pend;
    end

    // System domain register; strap wait starts pending
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s_r <= '0;
            s_r.brk_ctl <= dbgbrk_pkg::BREAK_CONTROL_RESET;     // see [RULE_18]
            s_r.strap_pend <= 1'b1;
            s_r.halt <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign CPU_HALT = s_r.halt;
    assign BREAK_PENDING = s_r.pend;

    // Checks on the system clock; the link busy check runs on the link clock
    sequence s_first_hit;
        CPU_ADDR_VALID && CPU_FIRST_OPCODE && any_hit
            && !s_r.halt && !s_r.strap_pend;
    endsequence

    sequence s_late_hit;
        CPU_ADDR_VALID && !CPU_FIRST_OPCODE && any_hit && !CPU_INSTR_END
            && !s_r.halt && !s_r.strap_pend && !wr_fire;
    endsequence

    sequence s_late_hit_end;
        CPU_ADDR_VALID && !CPU_FIRST_OPCODE && any_hit && CPU_INSTR_END
            && !s_r.halt && !s_r.strap_pend;
    endsequence

    property p_first_hit_halts;
        @(posedge CLK) disable iff (!RST_B)
        s_first_hit |=> CPU_HALT && s_r.brk_ctl[7];
    endproperty
    a_first_hit_halts: assert property (p_first_hit_halts) // see [RULE_04]
        else $error("first opcode match did not halt");

    property p_late_hit_defers;
        @(posedge CLK) disable iff (!RST_B)
        s_late_hit ##1 (!CPU_INSTR_END && !CPU_ADDR_VALID && !wr_fire)
            |=> BREAK_PENDING && !CPU_HALT;
    endproperty
    a_late_hit_defers: assert property (p_late_hit_defers) // see [RULE_05]
        else $error("non-first match halted early");

    property p_pend_at_end;
        @(posedge CLK) disable iff (!RST_B)
        (BREAK_PENDING && CPU_INSTR_END && !CPU_HALT)
            |=> CPU_HALT && !BREAK_PENDING;
    endproperty
    a_pend_at_end: assert property (p_pend_at_end) // see [RULE_10]
        else $error("deferred break missed boundary");

    property p_single_step;
        @(posedge CLK) disable iff (!RST_B)
        (s_r.brk_ctl[0] && CPU_INSTR_END && !CPU_HALT) |=> CPU_HALT;
    endproperty
    a_single_step: assert property (p_single_step) // see [RULE_16]
        else $error("single step did not halt");

    property p_release;
        @(posedge CLK) disable iff (!RST_B)
        (sw_wr_ctl && !l_r.data[7] && !hw_set && !s_r.strap_pend)
            |=> !CPU_HALT;
    endproperty
    a_release: assert property (p_release) // see [RULE_07]
        else $error("clearing break-next did not release");

    property p_force;
        @(posedge CLK) disable iff (!RST_B)
        (sw_wr_ctl && l_r.data[7]) |=> CPU_HALT [*2];
    endproperty
    a_force: assert property (p_force) // see [RULE_08]
        else $error("forced break not held");

    property p_disabled;
        @(posedge CLK) disable iff (!RST_B)
        (s_r.brk_ctl[6:3] == 4'h0) |-> !any_hit;
    endproperty
    a_disabled: assert property (p_disabled) // see [RULE_11]
        else $error("disabled comparators produced a hit");

    property p_strap;
        @(posedge CLK) disable iff (!RST_B)
        $fell(s_r.strap_pend) && $past(s_r.clk_s2) && !$past(s_r.dat_s2)
            |-> CPU_HALT;
    endproperty
    a_strap: assert property (p_strap) // see [RULE_09]
        else $error("strap break not taken");

    property p_compat_addr;
        @(posedge CLK) disable iff (!RST_B)
        !CPU_LONG_ADDRESS_MODE |-> cmp_addr[23:16] == CPU_MEMORY_BASE_BYTE;
    endproperty
    a_compat_addr: assert property (p_compat_addr) // see [RULE_03]
        else $error("16-bit mode upper byte wrong");

    property p_page_match;
        @(posedge CLK) disable iff (!RST_B)
        (s_r.brk_ctl[4] && s_r.brk_ctl[2] && s_r.brk_ctl[6:5] == 2'h0
            && !s_r.brk_ctl[3]) |-> any_hit == (cmp_addr[23:8] == s_r.bp[1][23:8]);
    endproperty
    a_page_match: assert property (p_page_match) // see [RULE_13]
        else $error("page match of comparator 1 wrong");

    property p_full_match;
        @(posedge CLK) disable iff (!RST_B)
        (s_r.brk_ctl[6:3] == 4'h2 && !s_r.brk_ctl[2])
            |-> any_hit == (cmp_addr == s_r.bp[1]);
    endproperty
    a_full_match: assert property (p_full_match) // see [RULE_12]
        else $error("full match of comparator 1 wrong");

    property p_long_addr;
        @(posedge CLK) disable iff (!RST_B)
        CPU_LONG_ADDRESS_MODE
            |-> cmp_addr == CPU_ADDR;
    endproperty
    a_long_addr: assert property (p_long_addr) // see [RULE_02]
        else $error("long mode address not the full bus");

    property p_page_match0;
        @(posedge CLK) disable iff (!RST_B)
        (s_r.brk_ctl[3] && s_r.brk_ctl[1] && s_r.brk_ctl[6:4] == 3'h0)
            |-> any_hit == (cmp_addr[23:8] == s_r.bp[0][23:8]);
    endproperty
    a_page_match0: assert property (p_page_match0) // see [RULE_15]
        else $error("page match of comparator 0 wrong");

    property p_late_hit_at_end;
        @(posedge CLK) disable iff (!RST_B)
        s_late_hit_end |=> CPU_HALT && !BREAK_PENDING;
    endproperty
    a_late_hit_at_end: assert property (p_late_hit_at_end) // see [RULE_05]
        else $error("late match in ending instruction lost");

    property p_link_busy;
        @(posedge DEBUG_CLOCK_PIN) disable iff (!RST_B)
        (LINK_WR && LINK_READY) |=> !LINK_READY;
    endproperty
    a_link_busy: assert property (p_link_busy) // see [RULE_06]
        else $error("link accepted write without going busy");
endmodule : dbgbrk_unit
`default_nettype wire

/* dbgbrk_host.sv */
// Debug host model driving the register link of the breakpoint unit
`timescale 1ns/10ps
`default_nettype none
module dbgbrk_host (
    output logic link_clk,         // Link clock, still between frames
    output logic data_pin,         // Data pin level, strap use only
    output logic link_wr,          // Write request
    output logic [7:0] link_addr,  // Register offset
    output logic [7:0] link_wdata, // Write data
    input wire logic link_ready    // Unit may take a write
);
    // Idle levels at time zero
    initial
    begin
        link_clk = 1'b0;
        data_pin = 1'b1;
        link_wr = 1'b0;
        link_addr = 8'h00;
        link_wdata = 8'h00;
    end

    // One short link edge inside reset, then the pins rest at strap levels
    task automatic strap(input logic c, input logic d);
        link_clk = 1'b0;
        #20;
        data_pin = d;
        link_clk = 1'b1;
        #20;
        link_clk = c;
    endtask : strap

    // One register write; held until taken, then ack awaited
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic rdy;
        logic seen_low;
        n = 0;
        rdy = 1'b0;
        seen_low = 1'b0;
        link_clk = 1'b0;
        #(1 + $urandom % 9);
        link_wr = 1'b1;
        link_addr = a;
        link_wdata = d;
        while (n < 40 && (link_wr || !seen_low || rdy !== 1'b1))
        begin
            #79;
            rdy = link_ready;
            link_clk = 1'b1;
            #1;
            if (!link_wr && rdy === 1'b0)
                seen_low = 1'b1;
            // Released lines show the inverse of their last value
            if (link_wr && rdy === 1'b1)
            begin
                link_wr = 1'b0;
                link_addr = ~a;
                link_wdata = ~d;
                rdy = 1'b0;
            end
            #80;
            link_clk = 1'b0;
            n++;
        end
    endtask : write
endmodule : dbgbrk_host
`default_nettype wire

/* dbgbrk_unit_tb.sv */
// Self-checking bench for the debug breakpoint unit
`timescale 1ns/10ps
`default_nettype none
module dbgbrk_unit_tb;
    logic clk, rst_b, link_clk, data_pin, link_wr, link_ready;
    logic [7:0] link_addr, link_wdata, cpu_base, ctl;
    logic cpu_valid, cpu_first, cpu_end, cpu_long, cpu_halt, brk_pend;
    logic [23:0] cpu_addr;
    logic [23:0] bp [4];
    int fail_count, comparisons, cyc;

    dbgbrk_unit dut (
        .CLK(clk),
        .RST_B(rst_b),
        .DEBUG_CLOCK_PIN(link_clk),
        .DEBUG_DATA_PIN(data_pin),
        .LINK_WR(link_wr),
        .LINK_ADDR(link_addr),
        .LINK_WDATA(link_wdata),
        .LINK_READY(link_ready),
        .CPU_ADDR_VALID(cpu_valid),
        .CPU_FIRST_OPCODE(cpu_first),
        .CPU_INSTR_END(cpu_end),
        .CPU_ADDR(cpu_addr),
        .CPU_MEMORY_BASE_BYTE(cpu_base),
        .CPU_LONG_ADDRESS_MODE(cpu_long),
        .CPU_HALT(cpu_halt),
        .BREAK_PENDING(brk_pend)
    );
    dbgbrk_host host (
        .link_clk(link_clk),
        .data_pin(data_pin),
        .link_wr(link_wr),
        .link_addr(link_addr),
        .link_wdata(link_wdata),
        .link_ready(link_ready)
    );

    // System clock, 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write(a, d);
        @(posedge clk);
        #1;
        chk(link_ready, 1'b1);
    endtask : wr

    task automatic set_bp(input int i, input logic [23:0] v);
        bp[i] = v;
        wr(8'(4 * i), v[7:0]);
        wr(8'(4 * i + 1), v[15:8]);
        wr(8'(4 * i + 2), v[23:16]);
    endtask : set_bp

    // Expected break for a compared address under the current control
    function automatic logic hit(input logic [23:0] a);
        logic h;
        logic ign;
        h = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ign = (i == 0) ? ctl[1] : (i == 1) ? ctl[2] : 1'b0;
            if (ctl[3 + i] && a[23:8] == bp[i][23:8])
                h = h | ign | (a[7:0] == bp[i][7:0]);
        end
        return h;
    endfunction : hit

    // One address cycle; 16-bit mode puts the top byte on the base byte
    task automatic fetch(input logic [23:0] a, input logic f, input logic lg);
        cpu_valid = 1'b1;
        cpu_first = f;
        cpu_long = lg;
        cpu_base = lg ? 8'($urandom) : a[23:16];
        cpu_addr = lg ? a : {8'($urandom), a[15:0]};
        @(posedge clk);
        #1;
        cpu_valid = 1'b0;
    endtask : fetch

    // Instruction boundary, then up to two edges for the halt
    task automatic end_instr;
        int n;
        n = 0;
        cpu_end = 1'b1;
        @(posedge clk);
        #1;
        cpu_end = 1'b0;
        while (cpu_halt !== 1'b1 && n < 2)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : end_instr

    task automatic do_reset(input logic c, input logic d);
        rst_b = 1'b0;
        host.strap(c, d);
        chk(cpu_halt, 1'b1);
        chk(link_ready, 1'b1);
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (10) @(posedge clk);
        #1;
    endtask : do_reset

    // Main sequence
    initial
    begin
        int k;
        logic [23:0] a;
        logic e;
        {cpu_valid, cpu_first, cpu_end, cpu_long} = 4'h0;
        cpu_addr = 24'h00_0000;
        cpu_base = 8'h00;
        ctl = 8'h00;
        rst_b = 1'b0;
        fail_count = 0;
        comparisons = 0;
        cyc = 0;
        void'($urandom(867));
        do_reset(1'b0, 1'b1);
        chk(cpu_halt, 1'b0);
        fetch(24'($urandom), 1'b1, 1'b1);
        chk(cpu_halt, 1'b0);
        for (int i = 0; i < 4; i++)
            set_bp(i, 24'($urandom));
        // Two comparators on one target give one break
        set_bp(2, bp[3]);
        ctl = 8'h60;
        wr(8'h10, ctl);
        fetch(bp[3], 1'b1, 1'b0);
        chk(cpu_halt, 1'b1);
        wr(8'h10, 8'h60);
        chk(cpu_halt, 1'b0);
        // Random comparators, enables, page ignores and address modes
        for (int n = 0; n < 25; n++)
        begin
            k = $urandom % 4;
            set_bp(k, 24'($urandom));
            ctl = {1'b0, 4'($urandom), 2'($urandom), 1'b0};
            wr(8'h10, ctl);
            a = bp[$urandom % 4];
            if ($urandom % 2)
                a[7:0] = 8'($urandom);
            if ($urandom % 4 == 0)
                a = 24'($urandom);
            e = hit(a);
            fetch(a, 1'b1, 1'($urandom));
            chk(cpu_halt, e);
            repeat (3) @(posedge clk);
            chk(cpu_halt, e);
            wr(8'h10, ctl);
            chk(cpu_halt, 1'b0);
        end
        // Match inside an instruction waits for its end
        ctl = 8'h08;
        wr(8'h10, ctl);
        fetch(bp[0], 1'b0, 1'b1);
        chk(brk_pend, 1'b1);
        chk(cpu_halt, 1'b0);
        end_instr();
        chk(cpu_halt, 1'b1);
        wr(8'h10, 8'h01);
        chk(cpu_halt, 1'b0);
        end_instr();
        chk(cpu_halt, 1'b1);
        // Late match in the very cycle its instruction ends
        wr(8'h10, 8'h08);
        cpu_end = 1'b1;
        fetch(bp[0], 1'b0, 1'b1);
        cpu_end = 1'b0;
        chk(cpu_halt, 1'b1);
        chk(brk_pend, 1'b0);
        wr(8'h10, 8'h00);
        wr(8'h10, 8'h80);
        chk(cpu_halt, 1'b1);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h80);
        wr(8'h03, 8'h80);
        chk(cpu_halt, 1'b0);
        // Strap at reset end forces a break before the first instruction
        do_reset(1'b1, 1'b0);
        chk(cpu_halt, 1'b1);
        wr(8'h10, 8'h00);
        chk(cpu_halt, 1'b0);
        fetch(bp[0], 1'b1, 1'b1);
        chk(cpu_halt, 1'b0);
        give_verdict();
    end
endmodule : dbgbrk_unit_tb
`default_nettype wire
